// file: logic/ctc_pkg.sv
`default_nettype none
// ****************************************
// Threshold compare constants
// ****************************************
package ctc_pkg;

  // Data and bus widths
  localparam int unsigned CTC_DATA_W   = 24;
  localparam int unsigned CTC_BUS_W    = 32;
  localparam int unsigned CTC_ADDR_W   = 8;
  localparam int unsigned CTC_IDX_W    = 6;
  localparam int unsigned CTC_IDX_LSB  = 2;
  localparam int unsigned CTC_NUM_LIM  = 5;
  localparam int unsigned CTC_BYTES    = 3;

  // Register indices; byte address is four times the index
  localparam logic [CTC_IDX_W-1:0] CTC_IDX_SLOT4_LOWER = 6'h24;
  localparam logic [CTC_IDX_W-1:0] CTC_IDX_SLOT5_LOWER = 6'h25;
  localparam logic [CTC_IDX_W-1:0] CTC_IDX_SLOT6_LOWER = 6'h26;
  localparam logic [CTC_IDX_W-1:0] CTC_IDX_SLOT7_LOWER = 6'h27;
  localparam logic [CTC_IDX_W-1:0] CTC_IDX_SLOT0_UPPER = 6'h28;
  localparam logic [CTC_IDX_W-1:0] CTC_IDX_CODING_CTRL = 6'h30;
  localparam logic [CTC_IDX_W-1:0] CTC_IDX_RANGE_STAT  = 6'h31;

  // Coding control fields
  localparam int unsigned CTC_BIT_UNIPOLAR  = 0;
  localparam int unsigned CTC_BIT_OFFSETBIN = 1;
  localparam int unsigned CTC_CTRL_W        = 2;

  // Status field positions: slots 4..7 under range, slot 0 over range
  localparam int unsigned CTC_BIT_S4_UNDER = 0;
  localparam int unsigned CTC_BIT_S5_UNDER = 1;
  localparam int unsigned CTC_BIT_S6_UNDER = 2;
  localparam int unsigned CTC_BIT_S7_UNDER = 3;
  localparam int unsigned CTC_BIT_S0_OVER  = 4;

  // Reset values
  localparam logic [CTC_DATA_W-1:0] CTC_LIMIT_RST = 24'h00_0000;
  localparam logic [CTC_CTRL_W-1:0] CTC_CTRL_RST  = 2'h0;
  localparam logic [CTC_BUS_W-1:0]  CTC_RD_NONE   = 32'h0000_0000;

  // Limit register order: four lower limits, then the upper one
  localparam logic [CTC_NUM_LIM-1:0] CTC_LIM_IS_UPPER = 5'h10;

endpackage : ctc_pkg
`default_nettype wire

// file: logic/ctc_cmp_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Compare carrier
// ****************************************
interface ctc_cmp_if;
  import ctc_pkg::*;

  logic [CTC_DATA_W-1:0] result;
  logic [CTC_DATA_W-1:0] limit;
  logic                  signed_mode;
  logic                  is_upper;
  logic                  outside;

  modport ctrl (output result, output limit, output signed_mode, output is_upper, input outside);
  modport cmp  (input result, input limit, input signed_mode, input is_upper, output outside);
endinterface : ctc_cmp_if
`default_nettype wire

// file: logic/ctc_limit_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// One limit comparator
// ****************************************
module ctc_limit_cmp
  import ctc_pkg::*;
(
  // Operands and outcome
  ctc_cmp_if.cmp port_if
);

  // Flip sign bit so twos-complement orders like unsigned
  function automatic logic [CTC_DATA_W-1:0] ctc_order_key(input logic [CTC_DATA_W-1:0] v, input logic sgn);
    ctc_order_key = sgn ? {~v[CTC_DATA_W-1], v[CTC_DATA_W-2:0]} : v;
  endfunction : ctc_order_key

  wire logic [CTC_DATA_W-1:0] res_key;
  wire logic [CTC_DATA_W-1:0] lim_key;

  // Strict compare; equal to the limit is inside range
  assign res_key         = ctc_order_key(port_if.result, port_if.signed_mode);
  assign lim_key         = ctc_order_key(port_if.limit, port_if.signed_mode);
  assign port_if.outside = port_if.is_upper ? (res_key > lim_key) : (res_key < lim_key);

endmodule : ctc_limit_cmp
`default_nettype wire

// file: logic/ctc_top.sv
`timescale 1ns/1ps
`default_nettype none
module ctc_top
  import ctc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  // Avalon-MM slave
  input  wire logic [CTC_ADDR_W-1:0] avs_address_in,
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic [CTC_BUS_W-1:0]  avs_writedata_in,
  input  wire logic [3:0]            avs_byteenable_in,
  output var  logic [CTC_BUS_W-1:0]  avs_readdata_out,
  output var  logic                  avs_waitrequest_out,
  // Conversion results from the core
  input  wire logic [CTC_DATA_W-1:0] slot0_result_in,
  input  wire logic [CTC_DATA_W-1:0] slot4_result_in,
  input  wire logic [CTC_DATA_W-1:0] slot5_result_in,
  input  wire logic [CTC_DATA_W-1:0] slot6_result_in,
  input  wire logic [CTC_DATA_W-1:0] slot7_result_in,
  // Range flags
  output var  logic                  slot4_under_range_flag_out,
  output var  logic                  slot5_under_range_flag_out,
  output var  logic                  slot6_under_range_flag_out,
  output var  logic                  slot7_under_range_flag_out,
  output var  logic                  slot0_over_range_flag_out
);

  // ****************************************
  // Reset release
  // ****************************************

  logic [1:0] rst_sync_q;
  wire  logic rst_n;

  // Two stages so release never lands near a clock edge
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************
  // Bus decode
  // ****************************************

  logic [CTC_DATA_W-1:0]  limit_q [CTC_NUM_LIM];
  logic [CTC_CTRL_W-1:0]  coding_q;
  logic [CTC_NUM_LIM-1:0] flags_q;
  logic                   wait_q;
  logic [CTC_BUS_W-1:0]   rdata_q;

  wire logic [CTC_IDX_W-1:0]  idx;
  wire logic                  req;
  wire logic                  accept;
  wire logic [CTC_NUM_LIM-1:0] lim_hit;
  wire logic                  ctrl_hit;
  wire logic                  stat_hit;
  wire logic [CTC_DATA_W-1:0] wmask;
  wire logic [CTC_BUS_W-1:0]  rdata_d;
  wire logic [CTC_DATA_W-1:0] results [CTC_NUM_LIM];
  wire logic [CTC_NUM_LIM-1:0] outside;
  wire logic                  signed_mode;

  // Request answered in the cycle after it is first seen
  assign req      = avs_read_in | avs_write_in;
  assign accept   = req & ~wait_q;
  assign idx      = avs_address_in[CTC_ADDR_W-1:CTC_IDX_LSB];
  assign ctrl_hit = (idx == CTC_IDX_CODING_CTRL);
  assign stat_hit = (idx == CTC_IDX_RANGE_STAT);
  assign lim_hit[0] = (idx == CTC_IDX_SLOT4_LOWER);
  assign lim_hit[1] = (idx == CTC_IDX_SLOT5_LOWER);
  assign lim_hit[2] = (idx == CTC_IDX_SLOT6_LOWER);
  assign lim_hit[3] = (idx == CTC_IDX_SLOT7_LOWER);
  assign lim_hit[4] = (idx == CTC_IDX_SLOT0_UPPER);

  // Byte lane mask for the three used lanes
  genvar b;
  generate
    for (b = 0; b < CTC_BYTES; b++) begin : g_mask
      assign wmask[b*8 +: 8] = {8{avs_byteenable_in[b]}};
    end
  endgenerate

  // One-hot hit vector to limit slot; zero when nothing hits
  function automatic logic [2:0] ctc_hit_slot(input logic [CTC_NUM_LIM-1:0] hit);
    ctc_hit_slot = '0;
    for (int k = 0; k < CTC_NUM_LIM; k++) begin
      if (hit[k]) begin
        ctc_hit_slot = 3'(k);
      end
    end
  endfunction : ctc_hit_slot

  // Read mux; unmapped addresses read zero, upper bits always zero
  wire logic [2:0]           lim_slot;
  wire logic [CTC_BUS_W-1:0] lim_rdata;
  wire logic [CTC_BUS_W-1:0] ctrl_rdata;
  wire logic [CTC_BUS_W-1:0] stat_rdata;
  assign lim_slot   = ctc_hit_slot(lim_hit);
  assign lim_rdata  = {{(CTC_BUS_W-CTC_DATA_W){1'b0}}, limit_q[lim_slot]};
  assign ctrl_rdata = {{(CTC_BUS_W-CTC_CTRL_W){1'b0}}, coding_q};
  assign stat_rdata = {{(CTC_BUS_W-CTC_NUM_LIM){1'b0}}, flags_q};
  assign rdata_d    = |lim_hit ? lim_rdata
                    : ctrl_hit ? ctrl_rdata
                    : stat_hit ? stat_rdata
                    : CTC_RD_NONE;

  // ****************************************
  // Bus handshake
  // ****************************************

  // Waitrequest high at rest, low for one cycle per request
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= CTC_RD_NONE;
    end else begin
      wait_q  <= ~(req & wait_q);
      rdata_q <= (req & wait_q & avs_read_in) ? rdata_d : rdata_q;
    end
  end
  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out    = rdata_q;

  // ****************************************
  // Limit and coding registers
  // ****************************************

  genvar i;
  generate
    for (i = 0; i < CTC_NUM_LIM; i++) begin : g_lim
      // limit storage, write masked by lanes
      always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
          limit_q[i] <= CTC_LIMIT_RST;
        end else if (accept && avs_write_in && lim_hit[i]) begin
          limit_q[i] <= (limit_q[i] & ~wmask) | (avs_writedata_in[CTC_DATA_W-1:0] & wmask);
        end
      end
    end
  endgenerate

  // Coding change does not rescale limits; software must rewrite them
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      coding_q <= CTC_CTRL_RST;
    end else if (accept && avs_write_in && ctrl_hit && avs_byteenable_in[0]) begin
      coding_q <= avs_writedata_in[CTC_CTRL_W-1:0];
    end
  end

  // ****************************************
  // Comparison
  // ****************************************

  assign signed_mode = ~coding_q[CTC_BIT_UNIPOLAR] & ~coding_q[CTC_BIT_OFFSETBIN];

  assign results[0] = slot4_result_in;
  assign results[1] = slot5_result_in;
  assign results[2] = slot6_result_in;
  assign results[3] = slot7_result_in;
  assign results[4] = slot0_result_in;

  ctc_cmp_if cmp_if [CTC_NUM_LIM] ();

  generate
    for (i = 0; i < CTC_NUM_LIM; i++) begin : g_cmp
      assign cmp_if[i].result      = results[i];
      assign cmp_if[i].limit       = limit_q[i];
      assign cmp_if[i].signed_mode = signed_mode;
      assign cmp_if[i].is_upper    = CTC_LIM_IS_UPPER[i];
      assign outside[i]            = cmp_if[i].outside;
      ctc_limit_cmp u_cmp (
        .port_if (cmp_if[i])
      );
    end
  endgenerate

  // ****************************************
  // Range flags
  // ****************************************

  // Not sticky: a flag drops once the result is back in range
  // Flags follow live results, one cycle late
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= outside;
    end
  end

  assign slot4_under_range_flag_out = flags_q[CTC_BIT_S4_UNDER];
  assign slot5_under_range_flag_out = flags_q[CTC_BIT_S5_UNDER];
  assign slot6_under_range_flag_out = flags_q[CTC_BIT_S6_UNDER];
  assign slot7_under_range_flag_out = flags_q[CTC_BIT_S7_UNDER];
  assign slot0_over_range_flag_out  = flags_q[CTC_BIT_S0_OVER];

endmodule : ctc_top
`default_nettype wire

// file: dv/ctc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Range flag checker
// ****************************************
module ctc_monitor
  import ctc_pkg::*;
(
  // Clock and reset
  input wire logic                  clk_in,
  input wire logic                  arst_n_in,
  // Register bus
  input wire logic                  avs_read_in,
  input wire logic                  avs_write_in,
  input wire logic                  avs_waitrequest_out,
  input wire logic [CTC_ADDR_W-1:0] avs_address_in,
  input wire logic [CTC_BUS_W-1:0]  avs_writedata_in,
  input wire logic [3:0]            avs_byteenable_in,
  // Conversion results
  input wire logic [CTC_DATA_W-1:0] slot0_result_in,
  input wire logic [CTC_DATA_W-1:0] slot4_result_in,
  input wire logic [CTC_DATA_W-1:0] slot5_result_in,
  input wire logic [CTC_DATA_W-1:0] slot6_result_in,
  input wire logic [CTC_DATA_W-1:0] slot7_result_in,
  // Flags
  input wire logic                  slot4_under_range_flag_out,
  input wire logic                  slot5_under_range_flag_out,
  input wire logic                  slot6_under_range_flag_out,
  input wire logic                  slot7_under_range_flag_out,
  input wire logic                  slot0_over_range_flag_out
);
  logic [CTC_DATA_W-1:0] lim_q [5];
  logic [1:0]            cod_q;
  logic [4:0]            want_q;
  wire  [5:0]            ix  = avs_address_in[7:2];
  wire                   sgn = cod_q == 2'h0;

  // Shadow limits, updated at the accepting edge like the real ones
  always_ff @(posedge clk_in or negedge arst_n_in)
    if (!arst_n_in) begin
      lim_q <= '{default: '0};
      cod_q <= 2'h0;
    end else if (avs_write_in && !avs_waitrequest_out) begin
      for (int b = 0; b < 3; b++)
        if (avs_byteenable_in[b] && ix >= 6'h24 && ix <= 6'h28)
          lim_q[ix-6'h24][b*8+:8] <= avs_writedata_in[b*8+:8];
      if (ix == CTC_IDX_CODING_CTRL && avs_byteenable_in[0]) cod_q <= avs_writedata_in[1:0];
    end

  // Strict less-than, signed only in two's complement coding
  function automatic logic lt(input logic [23:0] a, b, input logic s);
    return s ? $signed(a) < $signed(b) : a < b;
  endfunction : lt

  // Expected flags, registered so they line up with the design's
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      want_q <= '0;
    end else begin
      want_q <= {lt(lim_q[4], slot0_result_in, sgn), lt(slot7_result_in, lim_q[3], sgn),
                 lt(slot6_result_in, lim_q[2], sgn), lt(slot5_result_in, lim_q[1], sgn),
                 lt(slot4_result_in, lim_q[0], sgn)};
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  s4_under_a: assert property (slot4_under_range_flag_out == want_q[0])
    else $error("slot4 under flag wrong");
  s5_under_a: assert property (slot5_under_range_flag_out == want_q[1])
    else $error("slot5 under flag wrong");
  s6_under_a: assert property (slot6_under_range_flag_out == want_q[2])
    else $error("slot6 under flag wrong");
  s7_under_a: assert property (slot7_under_range_flag_out == want_q[3])
    else $error("slot7 under flag wrong");
  s0_over_a: assert property (slot0_over_range_flag_out == want_q[4])
    else $error("slot0 over flag wrong");
  signed_mode_a: assert property (sgn && !lim_q[0][23] && slot4_result_in[23] |=> slot4_under_range_flag_out)
    else $error("negative result not under");
  equal_limit_a: assert property (slot0_result_in == lim_q[4] |=> !slot0_over_range_flag_out)
    else $error("equal result flagged");
  wait_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered");
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");

  cover property (avs_write_in && !avs_waitrequest_out);
  cover property ($rose(slot4_under_range_flag_out));
  cover property (!sgn && slot0_over_range_flag_out);
endmodule : ctc_monitor

bind ctc_top ctc_monitor mon_u (
  .clk_in                     (clk_in),
  .arst_n_in                  (arst_n_in),
  .avs_read_in                (avs_read_in),
  .avs_write_in               (avs_write_in),
  .avs_waitrequest_out        (avs_waitrequest_out),
  .avs_address_in             (avs_address_in),
  .avs_writedata_in           (avs_writedata_in),
  .avs_byteenable_in          (avs_byteenable_in),
  .slot0_result_in            (slot0_result_in),
  .slot4_result_in            (slot4_result_in),
  .slot5_result_in            (slot5_result_in),
  .slot6_result_in            (slot6_result_in),
  .slot7_result_in            (slot7_result_in),
  .slot4_under_range_flag_out (slot4_under_range_flag_out),
  .slot5_under_range_flag_out (slot5_under_range_flag_out),
  .slot6_under_range_flag_out (slot6_under_range_flag_out),
  .slot7_under_range_flag_out (slot7_under_range_flag_out),
  .slot0_over_range_flag_out  (slot0_over_range_flag_out)
);
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
// ****************************************
// Threshold compare bench
// ****************************************
module tb_top;
  import ctc_pkg::*;
  logic        clk_in = 1'b0, arst_n_in = 1'b0, rd = 1'b0, wr = 1'b0, wait_o;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdat = '0, rdat, exp_v, seed = 32'h7a75;
  logic [3:0]  ben = 4'hf;
  logic [23:0] res [5] = '{default: '0}, lim [5];
  logic [1:0]  cod = 2'h0;
  wire logic [4:0] flg;
  logic [31:0] expq [$];
  int          miscompares = 0, num_checks = 0;

  initial forever #2.5 clk_in = ~clk_in;

  ctc_top dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(ben), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wait_o), .slot0_result_in(res[4]), .slot4_result_in(res[0]),
    .slot5_result_in(res[1]), .slot6_result_in(res[2]), .slot7_result_in(res[3]),
    .slot4_under_range_flag_out(flg[0]), .slot5_under_range_flag_out(flg[1]),
    .slot6_under_range_flag_out(flg[2]), .slot7_under_range_flag_out(flg[3]),
    .slot0_over_range_flag_out(flg[4]));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic lt(input logic [23:0] a, b, input logic s);
    return s ? $signed(a) < $signed(b) : a < b;
  endfunction : lt

  // Expected status word: four under flags, then the over flag
  function automatic logic [31:0] stat();
    logic [31:0] f;
    f = '0;
    for (int i = 0; i < 4; i++) f[i] = lt(res[i], lim[i], cod == 2'h0);
    f[4] = lt(lim[4], res[4], cod == 2'h0);
    return f;
  endfunction : stat

  // Holds the request until waitrequest is seen low, then idles one edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    rd <= !w; wr <= w; addr <= a; wdat <= d; ben <= b;
    do @(posedge clk_in); while (wait_o !== 1'b0);
    rd <= 1'b0; wr <= 1'b0;
    @(posedge clk_in);
  endtask : bus

  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : rdx

  // Read data taken at the edge that sees waitrequest low
  always @(posedge clk_in) if (rd && wait_o === 1'b0) begin
    exp_v = expq.pop_front();
    `CHK(rdat, exp_v)
    if (addr == 8'hc4) `CHK(32'(flg), exp_v)
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  initial begin
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    for (int i = 0; i < 5; i++) rdx(8'h90 + 8'(4 * i), 32'h0);
    rdx(8'hc4, 32'h0);
    $display("test reset done");
    // Random limits; the top byte of write data must be dropped
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      lim[i] = seed[23:0];
      bus(1'b1, 8'h90 + 8'(4 * i), seed, 4'hf);
    end
    rdx(8'h90, {8'h0, lim[0]});
    rdx(8'h94, {8'h0, lim[1]});
    rdx(8'h98, {8'h0, lim[2]});
    rdx(8'h9c, {8'h0, lim[3]});
    bus(1'b1, 8'h90, 32'hffaa_bbcc, 4'h2);
    lim[0][15:8] = 8'hbb;
    rdx(8'h90, {8'h0, lim[0]});
    bus(1'b1, 8'ha4, 32'h12_3456, 4'hf);
    rdx(8'ha4, 32'h0);
    rdx(8'ha0, {8'h0, lim[4]});
    $display("test access done");
    // Every coding mode: equal, sign flip, one below, one above, random
    for (int m = 0; m < 4; m++) begin
      cod = 2'(m);
      bus(1'b1, 8'hc0, 32'(m), 4'h1);
      seed = lfsr(seed);
      lim[m] = seed[23:0];
      bus(1'b1, 8'h90 + 8'(4 * m), seed, 4'hf);
      for (int k = 0; k < 12; k++) begin
        seed = lfsr(seed);
        for (int i = 0; i < 5; i++)
          res[i] <= k == 0 ? lim[i] : k == 1 ? lim[i] ^ 24'h80_0000 : k == 2 ? lim[i] - 24'h1 :
                    k == 3 ? lim[i] + 24'h1 : 24'(lfsr(seed + 32'(i)));
        @(posedge clk_in);
        rdx(8'hc4, stat());
      end
      $display("test coding %0d done", m);
    end
    repeat (2) @(posedge clk_in);
    close_out();
  end

  // Watchdog far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
